/* rtl/dsx_pkg.sv */
// Constants, opcodes and register map of the DSP execute unit.
package dsx_pkg;
  localparam logic [4:0] ADDR_INSTR = 5'h00;
  localparam logic [4:0] ADDR_ACC_A = 5'h04;
  localparam logic [4:0] ADDR_ACC_B = 5'h08;
  localparam logic [4:0] ADDR_ACC_R = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam logic [4:0] ADDR_OUT_BITS = 5'h14;
  localparam logic [4:0] ADDR_PC = 5'h18;
  localparam int OP_LSB = 0;
  localparam int SEL1_LSB = 5;
  localparam int SEL2_LSB = 7;
  localparam int COND_LSB = 5;
  localparam int IMM_LSB = 16;
  localparam int FLG_Z = 0;
  localparam int FLG_S = 1;
  localparam int FLG_O = 2;
  localparam int FLG_C = 3;
  localparam int STS_HALT = 4;
  localparam int STS_ILLEGAL = 5;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [15:0] OUT_RST = 16'h0000;
  localparam logic [7:0] PC_RST = 8'h00;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] LEN_TWO = 8'h02;

  typedef enum logic [1:0] {
    SEL_A = 2'h0,
    SEL_B = 2'h1,
    SEL_R = 2'h2,
    SEL_NONE = 2'h3
  } dsx_accumulator_select_t;

  typedef enum logic [4:0] {
    OP_ADD = 5'h00, OP_SIGN = 5'h01, OP_SUB = 5'h02, OP_INC = 5'h03,
    OP_INIT = 5'h04, OP_NOP = 5'h05, OP_RST = 5'h06, OP_STOP = 5'h07,
    OP_WDR = 5'h08, OP_RAD = 5'h09, OP_CLEAR = 5'h0a, OP_LOAD = 5'h0b,
    OP_LOAD2EXP = 5'h0c, OP_MOV = 5'h0d, OP_PUSH = 5'h0e, OP_POP = 5'h0f,
    OP_NOT = 5'h10, OP_AND = 5'h11, OP_OR = 5'h12, OP_XOR = 5'h13,
    OP_DIV = 5'h14, OP_MULT = 5'h15, OP_SHIFTL = 5'h16, OP_SHIFTR = 5'h17,
    OP_JUMP = 5'h18, OP_JSB = 5'h19, OP_JRT = 5'h1a,
    OP_CLEAR_OUTPUT_BIT = 5'h1b, OP_SET_OUTPUT_BIT = 5'h1c
  } dsx_opcode_t;

  typedef enum logic [3:0] {
    CND_ALWAYS = 4'h0, CND_CD = 4'h1, CND_BRANCH_IF_NO_CARRY = 4'h2,
    CND_CARRY = 4'h3, CND_EQ = 4'h4, CND_NE = 4'h5, CND_NEG = 4'h6,
    CND_NO_OVF = 4'h7, CND_OVF = 4'h8, CND_POS = 4'h9
  } dsx_cond_t;
endpackage : dsx_pkg

/* rtl/dsx_exec.sv */
// Execute unit for the DSP core instructions with an APB register port.
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Functional notes
// - Decode 29 distinct opcodes; any other code is flagged illegal.
// - AND puts p1 AND p2 into p1, updating all four flags.
// - ADD puts p1 plus p2 into p1, updating all four flags.
// - Clear-bit forces output bit 0..15 to zero, flags unchanged.
// - Set-bit forces output bit 0..15 to one, flags unchanged.
// - Clear writes zero to the selected accumulator, updating sign, zero.
// - Divide step works unsigned on a and r, updating sign, zero.
// - One divide step leaves quotient in b, twice remainder in a.
// - Repeated steps shift one more quotient bit into b each time.
// - Init resets the core and requests configuration reload.
// - Jump on carry clear loads target only while carry is zero.
module dsx_exec (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [4:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core outputs
  output logic [15:0] out_bits_o,
  output logic init_req_o,
  output logic halted_o
);
  logic [31:0] a_q, b_q, r_q, a_d, b_d, r_d, op1, op2, res;
  logic [3:0] flags_q, flags_d;
  logic [15:0] out_q, out_d;
  logic [7:0] pc_q, pc_d, target;
  logic [31:0] prdata_q;
  logic init_q, init_d, halt_q, halt_d, ill_q, ill_d;
  logic [32:0] sum33, dif33;
  logic [3:0] bit_idx;
  logic take, exec, unmapped, geq, set_sz, jump_ok;
  dsx_pkg::dsx_accumulator_select_t p1, p2;
  dsx_pkg::dsx_opcode_t op;
  dsx_pkg::dsx_cond_t cond;

  function automatic logic [31:0] acc_get(input logic [1:0] sel,
    input logic [31:0] a, input logic [31:0] b, input logic [31:0] r);
    case (sel)
      dsx_pkg::SEL_A: acc_get = a;
      dsx_pkg::SEL_B: acc_get = b;
      dsx_pkg::SEL_R: acc_get = r;
      default: acc_get = 32'h0000_0000;
    endcase
  endfunction : acc_get

  assign take = psel_i && penable_i;
  assign exec = take && pwrite_i && paddr_i == dsx_pkg::ADDR_INSTR;
  assign op = dsx_pkg::dsx_opcode_t'(pwdata_i[dsx_pkg::OP_LSB +: 5]);
  assign p1 = dsx_pkg::dsx_accumulator_select_t'(
    pwdata_i[dsx_pkg::SEL1_LSB +: 2]);
  assign p2 = dsx_pkg::dsx_accumulator_select_t'(
    pwdata_i[dsx_pkg::SEL2_LSB +: 2]);
  assign cond = dsx_pkg::dsx_cond_t'(pwdata_i[dsx_pkg::COND_LSB +: 4]);
  assign target = pwdata_i[dsx_pkg::IMM_LSB +: 8];
  assign bit_idx = pwdata_i[dsx_pkg::IMM_LSB +: 4];
  assign op1 = acc_get(p1, a_q, b_q, r_q);
  assign op2 = acc_get(p2, a_q, b_q, r_q);
  assign sum33 = {1'b0, op1} + {1'b0, op2};
  assign dif33 = {1'b0, op1} - {1'b0, op2};
  assign geq = a_q >= r_q;

  always_comb
  begin
    case (cond)
      dsx_pkg::CND_ALWAYS: jump_ok = 1'b1;
      dsx_pkg::CND_BRANCH_IF_NO_CARRY: jump_ok = !flags_q[dsx_pkg::FLG_C];
      dsx_pkg::CND_CARRY: jump_ok = flags_q[dsx_pkg::FLG_C];
      dsx_pkg::CND_EQ: jump_ok = flags_q[dsx_pkg::FLG_Z];
      dsx_pkg::CND_NE: jump_ok = !flags_q[dsx_pkg::FLG_Z];
      dsx_pkg::CND_NEG: jump_ok = flags_q[dsx_pkg::FLG_S];
      dsx_pkg::CND_POS: jump_ok = !flags_q[dsx_pkg::FLG_S];
      dsx_pkg::CND_NO_OVF: jump_ok = !flags_q[dsx_pkg::FLG_O];
      dsx_pkg::CND_OVF: jump_ok = flags_q[dsx_pkg::FLG_O];
      // The converter-done condition has no source here, so it never jumps.
      default: jump_ok = 1'b0;
    endcase
  end

  // Instruction datapath; only the selected targets change.
  always_comb
  begin
    a_d = a_q;
    b_d = b_q;
    r_d = r_q;
    res = 32'h0000_0000;
    flags_d = flags_q;
    out_d = out_q;
    pc_d = pc_q + dsx_pkg::LEN_ONE;
    init_d = 1'b0;
    halt_d = 1'b0;
    ill_d = 1'b0;
    set_sz = 1'b0;
    unique case (op)
      dsx_pkg::OP_ADD:
      begin
        res = sum33[31:0];
        flags_d[dsx_pkg::FLG_C] = sum33[32];
        flags_d[dsx_pkg::FLG_O] = op1[31] == op2[31] && res[31] != op1[31];
        set_sz = 1'b1;
      end
      dsx_pkg::OP_SUB:
      begin
        res = dif33[31:0];
        flags_d[dsx_pkg::FLG_C] = dif33[32];
        flags_d[dsx_pkg::FLG_O] = op1[31] != op2[31] && res[31] != op1[31];
        set_sz = 1'b1;
      end
      dsx_pkg::OP_INC:
      begin
        res = op1 + 32'h0000_0001;
        flags_d[dsx_pkg::FLG_C] = &op1;
        flags_d[dsx_pkg::FLG_O] = op1 == 32'h7fff_ffff;
        set_sz = 1'b1;
      end
      dsx_pkg::OP_SIGN, dsx_pkg::OP_NOT, dsx_pkg::OP_AND, dsx_pkg::OP_OR,
      dsx_pkg::OP_XOR, dsx_pkg::OP_SHIFTL, dsx_pkg::OP_SHIFTR:
      begin
        case (op)
          dsx_pkg::OP_SIGN: res = ~op1 + 32'h0000_0001;
          dsx_pkg::OP_NOT: res = ~op1;
          dsx_pkg::OP_AND: res = op1 & op2;
          dsx_pkg::OP_OR: res = op1 | op2;
          dsx_pkg::OP_XOR: res = op1 ^ op2;
          dsx_pkg::OP_SHIFTL: res = {op1[30:0], 1'b0};
          default: res = {1'b0, op1[31:1]};
        endcase
        flags_d[dsx_pkg::FLG_C] = op == dsx_pkg::OP_SHIFTL ? op1[31] :
          op == dsx_pkg::OP_SHIFTR ? op1[0] : 1'b0;
        flags_d[dsx_pkg::FLG_O] = 1'b0;
        set_sz = 1'b1;
      end
      dsx_pkg::OP_MOV:
        res = op2;
      dsx_pkg::OP_CLEAR:
      begin
        res = 32'h0000_0000;
        set_sz = 1'b1;
        pc_d = pc_q + dsx_pkg::LEN_TWO;
      end
      dsx_pkg::OP_DIV:
      begin
        // The doubled remainder wraps if r exceeds half the word range.
        b_d = {b_q[30:0], geq};
        a_d = geq ? (a_q - r_q) << 1 : a_q << 1;
        res = b_d;
        set_sz = 1'b1;
      end
      dsx_pkg::OP_JUMP:
        pc_d = jump_ok ? target : pc_q + dsx_pkg::LEN_TWO;
      dsx_pkg::OP_CLEAR_OUTPUT_BIT:
        out_d[bit_idx] = 1'b0;
      dsx_pkg::OP_SET_OUTPUT_BIT:
        out_d[bit_idx] = 1'b1;
      dsx_pkg::OP_INIT:
        init_d = 1'b1;
      dsx_pkg::OP_STOP:
        halt_d = 1'b1;
      // Memory, stack, multiply and watchdog codes live outside this unit.
      dsx_pkg::OP_NOP, dsx_pkg::OP_RST, dsx_pkg::OP_WDR, dsx_pkg::OP_RAD,
      dsx_pkg::OP_LOAD, dsx_pkg::OP_LOAD2EXP, dsx_pkg::OP_PUSH,
      dsx_pkg::OP_POP, dsx_pkg::OP_MULT, dsx_pkg::OP_JSB, dsx_pkg::OP_JRT:
        res = op1;
      default:
        ill_d = 1'b1;
    endcase
    if (set_sz)
    begin
      flags_d[dsx_pkg::FLG_S] = res[31];
      flags_d[dsx_pkg::FLG_Z] = res == 32'h0000_0000;
    end
    if (op != dsx_pkg::OP_DIV && op != dsx_pkg::OP_JUMP &&
        (op == dsx_pkg::OP_MOV || set_sz))
    begin
      case (p1)
        dsx_pkg::SEL_A: a_d = res;
        dsx_pkg::SEL_B: b_d = res;
        dsx_pkg::SEL_R: r_d = res;
        default: a_d = a_q;
      endcase
    end
  end

  // Accumulators: instruction results, else direct software writes.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      a_q <= dsx_pkg::ACC_RST;
      b_q <= dsx_pkg::ACC_RST;
      r_q <= dsx_pkg::ACC_RST;
    end
    else if (init_q)
    begin
      a_q <= dsx_pkg::ACC_RST;
      b_q <= dsx_pkg::ACC_RST;
      r_q <= dsx_pkg::ACC_RST;
    end
    else if (exec)
    begin
      a_q <= a_d;
      b_q <= b_d;
      r_q <= r_d;
    end
    else if (take && pwrite_i)
    begin
      if (paddr_i == dsx_pkg::ADDR_ACC_A)
        a_q <= pwdata_i;
      if (paddr_i == dsx_pkg::ADDR_ACC_B)
        b_q <= pwdata_i;
      if (paddr_i == dsx_pkg::ADDR_ACC_R)
        r_q <= pwdata_i;
    end
  end

  // Core state: flags, output bits, program counter and status.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      flags_q <= dsx_pkg::FLAGS_RST;
      out_q <= dsx_pkg::OUT_RST;
      pc_q <= dsx_pkg::PC_RST;
      init_q <= 1'b0;
      halt_q <= 1'b0;
      ill_q <= 1'b0;
    end
    else if (init_q)
    begin
      flags_q <= dsx_pkg::FLAGS_RST;
      out_q <= dsx_pkg::OUT_RST;
      pc_q <= dsx_pkg::PC_RST;
      init_q <= 1'b0;
      halt_q <= 1'b0;
      ill_q <= 1'b0;
    end
    else if (exec)
    begin
      flags_q <= flags_d;
      out_q <= out_d;
      pc_q <= pc_d;
      init_q <= init_d;
      halt_q <= halt_d;
      ill_q <= ill_d;
    end
    else if (take && pwrite_i && paddr_i == dsx_pkg::ADDR_PC)
      pc_q <= pwdata_i[7:0];
  end

  // Read data is captured in the setup cycle so the access needs no wait.
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      prdata_q <= 32'h0000_0000;
    else if (psel_i && !penable_i)
    begin
      case (paddr_i)
        dsx_pkg::ADDR_ACC_A: prdata_q <= a_q;
        dsx_pkg::ADDR_ACC_B: prdata_q <= b_q;
        dsx_pkg::ADDR_ACC_R: prdata_q <= r_q;
        dsx_pkg::ADDR_STATUS: prdata_q <= {26'h0, ill_q, halt_q, flags_q};
        dsx_pkg::ADDR_OUT_BITS: prdata_q <= {16'h0000, out_q};
        dsx_pkg::ADDR_PC: prdata_q <= {24'h00_0000, pc_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign unmapped = paddr_i[1:0] != 2'h0 || paddr_i > dsx_pkg::ADDR_PC;
  assign prdata_o = prdata_q;
  assign pready_o = 1'b1;
  assign pslverr_o = take && unmapped;
  assign out_bits_o = out_q;
  assign init_req_o = init_q;
  assign halted_o = halt_q;

  add_result_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_ADD && p1 == dsx_pkg::SEL_A &&
    p2 == dsx_pkg::SEL_B
    |=> a_q == $past(op1) + $past(op2) && flags_q[dsx_pkg::FLG_C] ==
    $past(sum33[32])) else $error("add result wrong");
  and_result_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_AND && p1 == dsx_pkg::SEL_A
    |=> a_q == ($past(op1) & $past(op2)) && flags_q[3:2] == 2'h0)
    else $error("and result wrong");
  bit_clear_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_CLEAR_OUTPUT_BIT |=> out_q ==
    ($past(out_q) & ~(16'h0001 << $past(bit_idx))))
    else $error("bit clear wrong");
  bit_set_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_SET_OUTPUT_BIT |=> out_q ==
    ($past(out_q) | (16'h0001 << $past(bit_idx))))
    else $error("bit set wrong");
  bit_flags_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && (op == dsx_pkg::OP_SET_OUTPUT_BIT ||
    op == dsx_pkg::OP_CLEAR_OUTPUT_BIT) |=> $stable(flags_q))
    else $error("bit op changed flags");
  clear_reg_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_CLEAR && p1 == dsx_pkg::SEL_B |=> b_q == 0 &&
    flags_q == {$past(flags_q[3:2]), 2'h1} && pc_q == $past(pc_q) + 8'h02)
    else $error("clear wrong");
  div_step_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_DIV |=> b_q[0] == $past(geq) &&
    b_q[31:1] == $past(b_q[30:0]) && flags_q[3:2] == $past(flags_q[3:2]))
    else $error("div step wrong");
  jump_nc_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_JUMP && cond == dsx_pkg::CND_BRANCH_IF_NO_CARRY
    |=> pc_q == ($past(flags_q[dsx_pkg::FLG_C]) ? $past(pc_q) + 8'h02 :
    $past(target))) else $error("jump on no carry wrong");
  init_pulse_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && op == dsx_pkg::OP_INIT |=> init_req_o ##1 !init_req_o &&
    a_q == 0 && pc_q == 0) else $error("init wrong");
  illegal_op_a: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    exec && pwdata_i[4:0] > 5'h1c |=> ill_q && $stable(a_q) && $stable(b_q))
    else $error("illegal opcode not flagged");
endmodule : dsx_exec

/* rtl/dsx_exec_unused_guard.sv */
// Holds no logic; the execute unit carries all of it.

/* tb/tb.sv */
// Self-checking bench for the DSP execute unit, driven over APB.
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [4:0] paddr_i = 5'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [15:0] out_bits_o;
  logic init_req_o;
  logic halted_o;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] rd_v;
  logic err_v;

  always #25 sys_clk_i = ~sys_clk_i;

  dsx_exec uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .out_bits_o(out_bits_o),
    .init_req_o(init_req_o), .halted_o(halted_o)
  );

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [4:0] addr,
                     input logic [31:0] wd);
    int i;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      @(posedge sys_clk_i);
      if (pready_o === 1'b1)
        break;
    end
    if (i == 10)
    begin
      n_fail++;
      give_verdict();
    end
    else
    begin
      rd_v = prdata_o;
      err_v = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
    end
  endtask : apb

  task automatic wr(input logic [4:0] addr, input logic [31:0] wd);
    apb(1'b1, addr, wd);
  endtask : wr

  task automatic rd(input string name, input logic [4:0] addr,
                    input logic [31:0] exp);
    apb(1'b0, addr, 32'h0000_0000);
    check(name, rd_v, exp);
  endtask : rd

  function automatic logic [31:0] ins(input logic [4:0] op,
    input logic [1:0] p1, input logic [1:0] p2, input logic [7:0] imm);
    return {8'h00, imm, 7'h00, p2, p1, op};
  endfunction : ins

  task automatic exe(input logic [31:0] w);
    wr(dsx_pkg::ADDR_INSTR, w);
  endtask : exe

  task automatic ab(input logic [31:0] a, input logic [31:0] b);
    wr(dsx_pkg::ADDR_ACC_A, a);
    wr(dsx_pkg::ADDR_ACC_B, b);
  endtask : ab

  initial
  begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd("status", dsx_pkg::ADDR_STATUS, 32'h0000_0000);
    // Carry out of the top bit with an all-zero sum.
    ab(32'hffff_ffff, 32'h0000_0001);
    exe(ins(dsx_pkg::OP_ADD, 2'h0, 2'h1, 8'h00));
    rd("add a", dsx_pkg::ADDR_ACC_A, 32'h0000_0000);
    rd("add flags", dsx_pkg::ADDR_STATUS, 32'h0000_0009);
    ab(32'hf0f0_1234, 32'h0ff0_ffff);
    exe(ins(dsx_pkg::OP_AND, 2'h0, 2'h1, 8'h00));
    rd("and a", dsx_pkg::ADDR_ACC_A, 32'h00f0_1234);
    rd("and flags", dsx_pkg::ADDR_STATUS, 32'h0000_0000);
    ab(32'h7fff_ffff, 32'h0000_0001);
    exe(ins(dsx_pkg::OP_ADD, 2'h0, 2'h1, 8'h00));
    rd("ovf a", dsx_pkg::ADDR_ACC_A, 32'h8000_0000);
    rd("ovf flags", dsx_pkg::ADDR_STATUS, 32'h0000_0006);
    exe(ins(dsx_pkg::OP_CLEAR, 2'h1, 2'h0, 8'h00));
    rd("clr b", dsx_pkg::ADDR_ACC_B, 32'h0000_0000);
    rd("clr flags", dsx_pkg::ADDR_STATUS, 32'h0000_0005);
    $display("arithmetic test done");
    for (int i = 0; i < 16; i++)
      exe(ins(dsx_pkg::OP_SET_OUTPUT_BIT, 2'h0, 2'h0, 8'(i)));
    // The last write lands at this very edge; let the register settle.
    #1;
    check("set all", {16'h0000, out_bits_o}, 32'h0000_ffff);
    for (int i = 0; i < 16; i += 2)
      exe(ins(dsx_pkg::OP_CLEAR_OUTPUT_BIT, 2'h0, 2'h0, 8'(i)));
    rd("bits", dsx_pkg::ADDR_OUT_BITS, 32'h0000_aaaa);
    check("pin bits", {16'h0000, out_bits_o}, 32'h0000_aaaa);
    rd("bit flags", dsx_pkg::ADDR_STATUS, 32'h0000_0005);
    $display("output bit test done");
    wr(dsx_pkg::ADDR_PC, 32'h0000_0010);
    exe(ins(dsx_pkg::OP_JUMP, 2'h2, 2'h0, 8'h40));
    rd("jump taken", dsx_pkg::ADDR_PC, 32'h0000_0040);
    ab(32'hffff_ffff, 32'h0000_0001);
    exe(ins(dsx_pkg::OP_ADD, 2'h0, 2'h1, 8'h00));
    wr(dsx_pkg::ADDR_PC, 32'h0000_0020);
    exe(ins(dsx_pkg::OP_JUMP, 2'h2, 2'h0, 8'h40));
    rd("jump skip", dsx_pkg::ADDR_PC, 32'h0000_0022);
    $display("jump test done");
    // Dividend 7, divisor 4: three steps give 7 = 1.75 * 2^2.
    ab(32'h0000_0007, 32'h0000_0000);
    wr(dsx_pkg::ADDR_ACC_R, 32'h0000_0004);
    exe(ins(dsx_pkg::OP_DIV, 2'h0, 2'h0, 8'h00));
    rd("div1 b", dsx_pkg::ADDR_ACC_B, 32'h0000_0001);
    rd("div1 a", dsx_pkg::ADDR_ACC_A, 32'h0000_0006);
    rd("div flags", dsx_pkg::ADDR_STATUS, 32'h0000_0008);
    exe(ins(dsx_pkg::OP_DIV, 2'h0, 2'h0, 8'h00));
    exe(ins(dsx_pkg::OP_DIV, 2'h0, 2'h0, 8'h00));
    rd("div3 b", dsx_pkg::ADDR_ACC_B, 32'h0000_0007);
    rd("div3 a", dsx_pkg::ADDR_ACC_A, 32'h0000_0000);
    rd("div3 r", dsx_pkg::ADDR_ACC_R, 32'h0000_0004);
    $display("division test done");
    exe(ins(5'h1d, 2'h0, 2'h0, 8'h00));
    rd("illegal", dsx_pkg::ADDR_STATUS, 32'h0000_0028);
    exe(ins(dsx_pkg::OP_NOP, 2'h0, 2'h0, 8'h00));
    rd("legal", dsx_pkg::ADDR_STATUS, 32'h0000_0008);
    $display("decode test done");
    wr(dsx_pkg::ADDR_ACC_A, 32'h0000_0005);
    exe(ins(dsx_pkg::OP_INIT, 2'h0, 2'h0, 8'h00));
    #1;
    check("init pulse", {31'h0, init_req_o}, 32'h0000_0001);
    @(posedge sys_clk_i);
    #1;
    check("init end", {31'h0, init_req_o}, 32'h0000_0000);
    rd("init a", dsx_pkg::ADDR_ACC_A, 32'h0000_0000);
    rd("init bits", dsx_pkg::ADDR_OUT_BITS, 32'h0000_0000);
    $display("init test done");
    exe(ins(dsx_pkg::OP_STOP, 2'h0, 2'h0, 8'h00));
    #1;
    check("halted pin", {31'h0, halted_o}, 32'h0000_0001);
    rd("halted", dsx_pkg::ADDR_STATUS, 32'h0000_0010);
    // Subtract borrows, and the next instruction also ends the halt.
    ab(32'h0000_0005, 32'h0000_0007);
    exe(ins(dsx_pkg::OP_SUB, 2'h0, 2'h1, 8'h00));
    rd("sub a", dsx_pkg::ADDR_ACC_A, 32'hffff_fffe);
    rd("sub flags", dsx_pkg::ADDR_STATUS, 32'h0000_000a);
    wr(dsx_pkg::ADDR_ACC_B, 32'hffff_ffff);
    exe(ins(dsx_pkg::OP_INC, 2'h1, 2'h0, 8'h00));
    rd("inc b", dsx_pkg::ADDR_ACC_B, 32'h0000_0000);
    rd("inc flags", dsx_pkg::ADDR_STATUS, 32'h0000_0009);
    exe(ins(dsx_pkg::OP_SHIFTL, 2'h0, 2'h0, 8'h00));
    rd("shl a", dsx_pkg::ADDR_ACC_A, 32'hffff_fffc);
    rd("shl flags", dsx_pkg::ADDR_STATUS, 32'h0000_000a);
    exe(ins(dsx_pkg::OP_MOV, 2'h2, 2'h0, 8'h00));
    rd("mov r", dsx_pkg::ADDR_ACC_R, 32'hffff_fffc);
    rd("mov flags", dsx_pkg::ADDR_STATUS, 32'h0000_000a);
    exe(ins(dsx_pkg::OP_SHIFTR, 2'h2, 2'h0, 8'h00));
    rd("shr r", dsx_pkg::ADDR_ACC_R, 32'h7fff_fffe);
    rd("shr flags", dsx_pkg::ADDR_STATUS, 32'h0000_0000);
    exe(ins(dsx_pkg::OP_NOT, 2'h0, 2'h0, 8'h00));
    rd("not a", dsx_pkg::ADDR_ACC_A, 32'h0000_0003);
    exe(ins(dsx_pkg::OP_SIGN, 2'h0, 2'h0, 8'h00));
    rd("sign a", dsx_pkg::ADDR_ACC_A, 32'hffff_fffd);
    rd("sign flags", dsx_pkg::ADDR_STATUS, 32'h0000_0002);
    exe(ins(dsx_pkg::OP_OR, 2'h0, 2'h2, 8'h00));
    rd("or a", dsx_pkg::ADDR_ACC_A, 32'hffff_ffff);
    exe(ins(dsx_pkg::OP_XOR, 2'h0, 2'h0, 8'h00));
    rd("xor a", dsx_pkg::ADDR_ACC_A, 32'h0000_0000);
    rd("xor flags", dsx_pkg::ADDR_STATUS, 32'h0000_0001);
    $display("alu test done");
    apb(1'b0, 5'h1c, 32'h0000_0000);
    check("unmapped err", {31'h0, err_v}, 32'h0000_0001);
    check("unmapped data", rd_v, 32'h0000_0000);
    wr(5'h06, 32'h1234_5678);
    check("unaligned err", {31'h0, err_v}, 32'h0000_0001);
    rd("a kept", dsx_pkg::ADDR_ACC_A, 32'h0000_0000);
    $display("address map test done");
    give_verdict();
  end
endmodule : tb
